/* logic/hbm_pkg.sv */
/*
  Shared constants and types for the host bus mailbox interface.
  Assumes one 100 MHz clock and an active-low asynchronous reset.

// Notes on behaviour
// - Sixteen 16-bit mailbox words, reachable from both sides
// - Simultaneous reads, and read beside write, both work
// - Lowest four words hold local control and status
// - Remaining twelve words are general purpose
// - Host write to word zero traps local processor
// - Before init, host sees word zero only
// - After init, two secondary words raise level five
// - Local processor fetches command from word zero
// - Write-only vector register takes 0 to 1774 octal
// - Local vector write raises host interrupt request
// - Host acknowledge makes device drive stored vector
// - Host interrupts use level four, 8-bit vector
// - Host starts every transfer; device waits for command
// - Device is slave, master only for DMA
// - Multiplexed 22-bit address, 16-bit data bus path
// - Block transfers support four direction codes
// - Host parameters in mailbox; local programs controller
// - Host-boot holds after tests until word zero command
*/
package hbm_pkg;

  // Widths
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int IDX_W  = 4;
  localparam int WORDS  = 16;

  // Mailbox word indices
  localparam logic [3:0] CMD_IDX      = 4'h0;
  localparam logic [3:0] SYS_LAST_IDX = 4'h3;
  localparam logic [3:0] SEC_A_IDX    = 4'h4;
  localparam logic [3:0] SEC_B_IDX    = 4'h5;

  // Local register indices; 0x00 to 0x0F are the mailbox words
  localparam logic [4:0] LOC_VEC_IDX  = 5'h10;
  localparam logic [4:0] LOC_CTRL_IDX = 5'h11;
  localparam logic [4:0] LOC_STAT_IDX = 5'h12;

  // Control register fields
  localparam int CTRL_INIT_BIT  = 0;
  localparam int CTRL_TESTS_BIT = 1;
  localparam int CTRL_HBOOT_BIT = 2;
  localparam int CTRL_GO_BIT    = 3;
  localparam int CTRL_DIR_LSB   = 4;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // Vector register limits and reset value
  localparam logic [15:0] VEC_MAX   = 16'h03FC;
  localparam logic [7:0]  VEC_RESET = 8'h00;
  localparam logic [15:0] DATA_ZERO = 16'h0000;

  // Block transfer directions
  typedef enum logic [1:0] {
    DIR_LOC_TO_GLB  = 2'b00,
    DIR_GLB_TO_LOC  = 2'b01,
    DIR_GLB_TO_LOC2 = 2'b10,
    DIR_LOC_TO_LOC  = 2'b11
  } hbm_dir_e;

  // Host bus strobes and multiplexed lines, sampled each cycle
  typedef struct packed {
    logic              sync;
    logic              read;
    logic              write;
    logic              iack;
    logic [ADDR_W-1:0] dal;
  } hbm_host_cmd_s;

  // Local processor register access
  typedef struct packed {
    logic              sel;
    logic              wr;
    logic [4:0]        addr;
    logic [DATA_W-1:0] wdata;
  } hbm_loc_req_s;

endpackage

/* logic/hbm_mailbox_file.sv */
/*
  Sixteen-word dual-port mailbox store.
  Assumes the caller decodes access rights; host write wins a same-word clash.
*/
`timescale 1ns/1ps
module hbm_mailbox_file (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  // Host port
  input  wire logic                 h_we_in,
  input  wire logic [3:0]           h_idx_in,
  input  wire logic [15:0]          h_wdata_in,
  output logic      [15:0]          h_rdata_out,
  // Local port
  input  wire logic                 l_we_in,
  input  wire logic [3:0]           l_idx_in,
  input  wire logic [15:0]          l_wdata_in,
  output logic      [15:0]          l_rdata_out
);

  logic [15:0] mem_r [hbm_pkg::WORDS];

  // Both read ports are independent; a read beside a write sees old data
  assign h_rdata_out = mem_r[h_idx_in];
  assign l_rdata_out = mem_r[l_idx_in];

  // Write ports; host takes priority on the same word
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < hbm_pkg::WORDS; i++) mem_r[i] <= hbm_pkg::DATA_ZERO;
    end else begin
      if (l_we_in && !(h_we_in && h_idx_in == l_idx_in)) mem_r[l_idx_in] <= l_wdata_in;
      if (h_we_in) mem_r[h_idx_in] <= h_wdata_in;
    end
  end

endmodule // hbm_mailbox_file

/* logic/hbm_vector_reg.sv */
/*
  Write-only host interrupt vector register with its pending request.
  Assumes one-cycle write and delivery pulses from the top module.
*/
`timescale 1ns/1ps
module hbm_vector_reg (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Local write
  input  wire logic        wr_in,
  input  wire logic [15:0] wdata_in,
  // Delivery on acknowledge
  input  wire logic        delivered_in,
  output logic      [15:0] vec_out,
  output logic             pending_out
);

  logic [7:0] vec_r;
  logic       pend_r;
  wire        in_range = (wdata_in <= hbm_pkg::VEC_MAX);

  // Vector kept as 8 bits, word aligned on the bus
  assign vec_out     = {6'h00, vec_r, 2'h0};
  assign pending_out = pend_r;

  // New write wins over delivery in the same cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vec_r  <= hbm_pkg::VEC_RESET;
      pend_r <= 1'b0;
    end else begin
      if (wr_in && in_range) vec_r <= wdata_in[9:2];
      if (wr_in && in_range) pend_r <= 1'b1;
      else if (delivered_in) pend_r <= 1'b0;
    end
  end

endmodule // hbm_vector_reg

/* logic/hbm_mailbox_top.sv */
/*
  Host bus mailbox interface: slave on the multiplexed backplane bus,
  dual-port mailbox, host interrupt vector and block transfer set-up.
  Assumes host strobes are synchronous to clk_in and the block transfer
  controller sits outside, handshaking over dma_req_out and dma_gnt_in.
*/
`timescale 1ns/1ps
module hbm_mailbox_top #(
  parameter logic [16:0] HOST_BASE = 17'h1FFF0
) (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  // Backplane bus, host side
  input  wire hbm_pkg::hbm_host_cmd_s host_cmd_in,
  output logic      [21:0]           host_dal_out,
  output logic                       host_dal_oe_out,
  output logic                       host_reply_out,
  output logic                       host_irq4_out,
  // Local processor register port
  input  wire hbm_pkg::hbm_loc_req_s  loc_req_in,
  output logic      [15:0]           loc_rdata_out,
  output logic                       loc_nmi_out,
  output logic                       loc_lvl5_irq_out,
  // Block transfer controller
  input  wire logic                  dma_gnt_in,
  input  wire logic                  dma_done_in,
  output logic                       dma_req_out,
  output logic                       dma_master_out,
  output logic      [1:0]            dma_dir_out,
  output logic                       boot_hold_out,
  output logic                       boot_load_out
);

  // Host bus slave states
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_ADDR = 3'b001,
    H_RD   = 3'b010,
    H_WR   = 3'b011,
    H_VEC  = 3'b100,
    H_HOLD = 3'b101
  } hbm_hstate_e;

  // Boot sequencing states
  typedef enum logic [1:0] {
    B_IDLE = 2'b00,
    B_HOLD = 2'b01,
    B_LOAD = 2'b10,
    B_RUN  = 2'b11
  } hbm_bstate_e;

  hbm_hstate_e h_state_r;
  hbm_hstate_e h_state_nxt;
  hbm_bstate_e b_state_r;
  hbm_bstate_e b_state_nxt;

  logic [21:0] addr_r;
  logic [5:0]  ctrl_r;
  logic        dma_req_r;
  logic        dma_act_r;

  // Mailbox and vector connections
  logic [15:0] h_rdata;
  logic [15:0] l_rdata;
  logic [15:0] vec_word;
  logic        vec_pend;

  // Host address decode: base match, even byte, word index
  wire         addr_hit  = (addr_r[21:5] == HOST_BASE) && !addr_r[0];
  wire [3:0]   h_idx     = addr_r[4:1];
  wire         init_done = ctrl_r[hbm_pkg::CTRL_INIT_BIT];
  wire         allowed   = addr_hit && (init_done || h_idx == hbm_pkg::CMD_IDX);
  wire         sec_idx   = (h_idx == hbm_pkg::SEC_A_IDX) || (h_idx == hbm_pkg::SEC_B_IDX);

  // Host strobe qualifiers
  wire         strobes   = host_cmd_in.read || host_cmd_in.write || host_cmd_in.iack;
  wire         host_we   = (h_state_r == H_WR);
  wire         vec_done  = (h_state_r == H_VEC);
  wire         cmd_write = host_we && (h_idx == hbm_pkg::CMD_IDX);

  // Local decode
  wire         loc_wr    = loc_req_in.sel && loc_req_in.wr;
  wire         loc_rd    = loc_req_in.sel && !loc_req_in.wr;
  wire         loc_mbox  = !loc_req_in.addr[4];
  wire         loc_mb_we = loc_wr && loc_mbox;
  wire         loc_vec_we = loc_wr && (loc_req_in.addr == hbm_pkg::LOC_VEC_IDX);
  wire         loc_ctl_we = loc_wr && (loc_req_in.addr == hbm_pkg::LOC_CTRL_IDX);
  wire         dma_go    = loc_ctl_we && loc_req_in.wdata[hbm_pkg::CTRL_GO_BIT];

  // Status word seen by the local processor
  wire [15:0]  status_word = {10'h000, dma_act_r, dma_req_r, vec_pend, b_state_r, init_done};

  // Local read selection; the vector register is write-only
  wire [15:0]  loc_rsel =
    loc_mbox                                      ? l_rdata     :
    (loc_req_in.addr == hbm_pkg::LOC_CTRL_IDX)   ? {10'h000, ctrl_r} :
    (loc_req_in.addr == hbm_pkg::LOC_STAT_IDX)   ? status_word :
                                                   hbm_pkg::DATA_ZERO;

  // Mailbox store shared by both sides
  hbm_mailbox_file u_mbox (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .h_we_in     (host_we),
    .h_idx_in    (h_idx),
    .h_wdata_in  (host_cmd_in.dal[15:0]),
    .h_rdata_out (h_rdata),
    .l_we_in     (loc_mb_we),
    .l_idx_in    (loc_req_in.addr[3:0]),
    .l_wdata_in  (loc_req_in.wdata),
    .l_rdata_out (l_rdata)
  );

  // Vector register and its pending request
  hbm_vector_reg u_vec (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .wr_in        (loc_vec_we),
    .wdata_in     (loc_req_in.wdata),
    .delivered_in (vec_done),
    .vec_out      (vec_word),
    .pending_out  (vec_pend)
  );

  // Host slave next state; sync alone reaches H_ADDR, but a reply needs a host strobe
  always_comb begin
    h_state_nxt = h_state_r;
    unique case (h_state_r)
      H_IDLE: begin
        if (host_cmd_in.iack && vec_pend) h_state_nxt = H_VEC;
        else if (host_cmd_in.sync) h_state_nxt = H_ADDR;
      end
      H_ADDR: begin
        if (!host_cmd_in.sync) h_state_nxt = H_IDLE;
        else if (allowed && host_cmd_in.read) h_state_nxt = H_RD;
        else if (allowed && host_cmd_in.write) h_state_nxt = H_WR;
      end
      H_RD:   h_state_nxt = H_HOLD;
      H_WR:   h_state_nxt = H_HOLD;
      H_VEC:  h_state_nxt = H_HOLD;
      H_HOLD: begin
        if (!strobes) h_state_nxt = host_cmd_in.sync ? H_ADDR : H_IDLE;
      end
      default: h_state_nxt = H_IDLE;
    endcase
  end

  // Host slave state and address latch
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      h_state_r <= H_IDLE;
      addr_r    <= 22'h000000;
    end else begin
      h_state_r <= h_state_nxt;
      if (h_state_r == H_IDLE && host_cmd_in.sync) addr_r <= host_cmd_in.dal;
    end
  end

  // Bus drivers: data only for a host read or an acknowledge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      host_dal_out    <= 22'h000000;
      host_dal_oe_out <= 1'b0;
      host_reply_out  <= 1'b0;
    end else begin
      if (h_state_r == H_RD) host_dal_out <= {6'h00, h_rdata};
      else if (vec_done) host_dal_out <= {6'h00, vec_word};
      if (h_state_r == H_RD || vec_done) host_dal_oe_out <= 1'b1;
      else if (h_state_r == H_HOLD && !strobes) host_dal_oe_out <= 1'b0;
      if (h_state_r == H_RD || h_state_r == H_WR || vec_done) host_reply_out <= 1'b1;
      else if (h_state_r == H_HOLD && !strobes) host_reply_out <= 1'b0;
    end
  end

  // Host interrupt request follows the pending vector
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      host_irq4_out <= 1'b0;
    end else begin
      host_irq4_out <= vec_pend && !vec_done;
    end
  end

  // Local interrupts raised by host mailbox writes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      loc_nmi_out      <= 1'b0;
      loc_lvl5_irq_out <= 1'b0;
    end else begin
      loc_nmi_out      <= cmd_write;
      loc_lvl5_irq_out <= host_we && init_done && sec_idx;
    end
  end

  // Local read data, registered one cycle after the request
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      loc_rdata_out <= hbm_pkg::DATA_ZERO;
    end else if (loc_rd) begin
      loc_rdata_out <= loc_rsel;
    end
  end

  // Control register; the go bit is a one-cycle command
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r <= hbm_pkg::CTRL_RESET;
    end else if (loc_ctl_we) begin
      ctrl_r <= {loc_req_in.wdata[5:4], 1'b0, loc_req_in.wdata[2:0]};
    end
  end

  // Boot sequencing next state
  always_comb begin
    b_state_nxt = b_state_r;
    unique case (b_state_r)
      B_IDLE: begin
        if (ctrl_r[hbm_pkg::CTRL_HBOOT_BIT] && ctrl_r[hbm_pkg::CTRL_TESTS_BIT])
          b_state_nxt = B_HOLD;
      end
      B_HOLD: begin
        if (cmd_write) b_state_nxt = B_LOAD;
      end
      B_LOAD: begin
        if (dma_act_r && dma_done_in) b_state_nxt = B_RUN;
      end
      B_RUN:  b_state_nxt = B_RUN;
    endcase
  end

  // Boot state and its outputs
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      b_state_r     <= B_IDLE;
      boot_hold_out <= 1'b0;
      boot_load_out <= 1'b0;
    end else begin
      b_state_r     <= b_state_nxt;
      boot_hold_out <= (b_state_nxt == B_HOLD);
      boot_load_out <= (b_state_nxt == B_LOAD);
    end
  end

  // Bus mastership request: local go or a boot load
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dma_req_r <= 1'b0;
      dma_act_r <= 1'b0;
    end else begin
      if (dma_go || (b_state_r == B_HOLD && cmd_write)) dma_req_r <= 1'b1;
      else if (dma_gnt_in) dma_req_r <= 1'b0;
      if (dma_req_r && dma_gnt_in) dma_act_r <= 1'b1;
      else if (dma_done_in) dma_act_r <= 1'b0;
    end
  end

  // Controller-facing outputs
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dma_req_out    <= 1'b0;
      dma_master_out <= 1'b0;
      dma_dir_out    <= hbm_pkg::DIR_LOC_TO_GLB;
    end else begin
      dma_req_out    <= dma_req_r;
      dma_master_out <= dma_act_r && !dma_done_in;
      dma_dir_out    <= (b_state_nxt == B_LOAD) ? hbm_pkg::DIR_GLB_TO_LOC
                        : ctrl_r[5:4];
    end
  end

endmodule // hbm_mailbox_top

/* dv/hbm_mailbox_top_monitor.sv */
/*
  Checker for the host bus mailbox top: bus answers, interrupts, DMA.
  Assumes it is bound onto hbm_mailbox_top; one clock, active-low reset.
*/
`timescale 1ns/1ps
module hbm_mailbox_top_monitor (
  // Clock and reset
  input wire logic                   clk_in,
  input wire logic                   rst_n_in,
  // Host side
  input wire hbm_pkg::hbm_host_cmd_s host_cmd_in,
  input wire logic [21:0]            host_dal_out,
  input wire logic                   host_dal_oe_out,
  input wire logic                   host_reply_out,
  input wire logic                   host_irq4_out,
  // Local side
  input wire hbm_pkg::hbm_loc_req_s  loc_req_in,
  input wire logic [15:0]            loc_rdata_out,
  input wire logic                   loc_nmi_out,
  input wire logic                   loc_lvl5_irq_out,
  // Block transfer
  input wire logic                   dma_gnt_in,
  input wire logic                   dma_done_in,
  input wire logic                   dma_req_out,
  input wire logic                   dma_master_out,
  input wire logic [1:0]             dma_dir_out,
  input wire logic                   boot_hold_out,
  input wire logic                   boot_load_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // In-range local write of the vector register
  sequence s_vec_write;
    loc_req_in.sel && loc_req_in.wr && loc_req_in.addr == hbm_pkg::LOC_VEC_IDX
      && loc_req_in.wdata <= hbm_pkg::VEC_MAX;
  endsequence
  // Any host strobe held
  sequence s_host_strobe;
    host_cmd_in.read || host_cmd_in.write || host_cmd_in.iack;
  endsequence

  // Bus answers follow host commands; host request follows vector write; DMA follows grant
  a_irq_after_vec: assert property (s_vec_write |-> ##2 host_irq4_out)
    else $error("request missing after vector write");
  a_irq_holds_wait: assert property (host_irq4_out && !host_cmd_in.iack |=> host_irq4_out)
    else $error("request dropped without acknowledge");
  a_irq_drop_ack: assert property ($rose(host_reply_out) && host_cmd_in.iack |-> !host_irq4_out)
    else $error("request still up at vector delivery");
  a_reply_after_cmd: assert property ($rose(host_reply_out) |->
    $past(host_cmd_in.read || host_cmd_in.write || host_cmd_in.iack, 2))
    else $error("reply without host strobe");
  a_reply_stands_on: assert property (s_host_strobe ##0 host_reply_out |=> host_reply_out)
    else $error("reply dropped under strobe");
  a_oe_after_cmd: assert property (host_dal_oe_out |->
    $past(host_cmd_in.read || host_cmd_in.iack) || $past(host_cmd_in.read || host_cmd_in.iack, 2))
    else $error("bus driven without read or acknowledge");
  a_dal_upper_zero: assert property (host_dal_oe_out |-> host_dal_out[21:16] == 6'h00)
    else $error("upper bus lines not zero");
  a_vec_word_align: assert property (host_dal_oe_out && host_cmd_in.iack |->
    host_dal_out[1:0] == 2'b00)
    else $error("vector not word aligned");
  a_nmi_one_pulse: assert property (loc_nmi_out |->
    host_reply_out && host_cmd_in.write ##1 !loc_nmi_out)
    else $error("trap pulse without host write");
  a_lvl5_on_write: assert property (loc_lvl5_irq_out |-> host_reply_out && host_cmd_in.write)
    else $error("level five without host write");
  a_master_after_gnt: assert property ($rose(dma_master_out) |-> $past(dma_gnt_in))
    else $error("master without grant");
  a_req_drops_gnt: assert property (dma_req_out && dma_gnt_in |-> ##[1:2] !dma_req_out)
    else $error("request kept after grant");
  a_boot_load_dir: assert property (boot_load_out |-> dma_dir_out == 2'b01)
    else $error("boot load in wrong direction");
endmodule // hbm_mailbox_top_monitor

bind hbm_mailbox_top hbm_mailbox_top_monitor u_monitor (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .host_cmd_in(host_cmd_in),
  .host_dal_out(host_dal_out), .host_dal_oe_out(host_dal_oe_out),
  .host_reply_out(host_reply_out), .host_irq4_out(host_irq4_out),
  .loc_req_in(loc_req_in), .loc_rdata_out(loc_rdata_out), .loc_nmi_out(loc_nmi_out),
  .loc_lvl5_irq_out(loc_lvl5_irq_out), .dma_gnt_in(dma_gnt_in), .dma_done_in(dma_done_in),
  .dma_req_out(dma_req_out), .dma_master_out(dma_master_out), .dma_dir_out(dma_dir_out),
  .boot_hold_out(boot_hold_out), .boot_load_out(boot_load_out)
);

/* dv/hbm_host_model.sv */
/*
  Host arbiter model: runs write, read and acknowledge cycles on the bus.
  Assumes the bench calls its task; strobes change at falling edges.
*/
`timescale 1ns/1ps
module hbm_host_model (
  // Clock
  input  wire logic             clk_in,
  // Device answer
  input  wire logic             reply_in,
  input  wire logic [21:0]      dal_in,
  // Host strobes
  output hbm_pkg::hbm_host_cmd_s cmd_out
);
  // Bus idle at start
  initial cmd_out = '0;

  // One cycle, kind {iack,read,write}; strobe held until reply seen high or 8 clocks pass
  task automatic cycle(input logic [2:0] kind, input logic [21:0] adr, input logic [15:0] wd,
                       output logic [21:0] rd, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    rd = '0;
    @(negedge clk_in);
    cmd_out.sync = !kind[2];
    cmd_out.dal = adr;
    @(negedge clk_in);
    {cmd_out.iack, cmd_out.read, cmd_out.write} = kind;
    cmd_out.dal = kind[0] ? {6'h00, wd} : ~adr; // Read and acknowledge drive the address complement here; the release below restores the address
    while (n < 8 && !ok) begin
      @(posedge clk_in);
      ok = reply_in;
      rd = dal_in;
      n++;
    end
    @(negedge clk_in);
    cmd_out = {4'h0, ~cmd_out.dal};
    repeat (3) @(negedge clk_in);
  endtask
endmodule // hbm_host_model

/* dv/hbm_mailbox_top_test.sv */
/*
  Self-checking bench for the host bus mailbox top.
  Assumes the host model on the bus side and the bench on the local side.
*/
`timescale 1ns/1ps
module hbm_mailbox_top_test;
  localparam logic [16:0] HBASE = 17'h1FFF0;
  // Design-facing signals and bench state
  logic                   clk_in, rst_n_in, dma_gnt_in, dma_done_in, rd_pend, reply_d;
  hbm_pkg::hbm_host_cmd_s host_cmd_in;
  hbm_pkg::hbm_loc_req_s  loc_req_in;
  logic [21:0]            host_dal_out;
  logic [15:0]            loc_rdata_out;
  logic [1:0]             dma_dir_out;
  logic                   host_dal_oe_out, host_reply_out, host_irq4_out, loc_nmi_out;
  logic                   loc_lvl5_irq_out, dma_req_out, dma_master_out, boot_hold_out;
  logic                   boot_load_out;
  logic [21:0]            exp_q[$];
  int                     n_mismatch = 0, n_compared = 0, n_nmi = 0, n_lvl5 = 0;

  // Clock
  initial clk_in = 1'b0;
  always #5 clk_in = ~clk_in;

  hbm_mailbox_top #(.HOST_BASE(HBASE)) u_hbm_mailbox_top (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .host_cmd_in(host_cmd_in),
    .host_dal_out(host_dal_out), .host_dal_oe_out(host_dal_oe_out),
    .host_reply_out(host_reply_out), .host_irq4_out(host_irq4_out),
    .loc_req_in(loc_req_in), .loc_rdata_out(loc_rdata_out), .loc_nmi_out(loc_nmi_out),
    .loc_lvl5_irq_out(loc_lvl5_irq_out), .dma_gnt_in(dma_gnt_in), .dma_done_in(dma_done_in),
    .dma_req_out(dma_req_out), .dma_master_out(dma_master_out), .dma_dir_out(dma_dir_out),
    .boot_hold_out(boot_hold_out), .boot_load_out(boot_load_out));
  hbm_host_model u_hbm_host_model (.clk_in(clk_in), .reply_in(host_reply_out),
    .dal_in(host_dal_out), .cmd_out(host_cmd_in));

  // Compare and count
  task automatic chk(input string nm, input logic [21:0] e, input logic [21:0] g);
    n_compared++;
    if (e !== g) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One local access cycle
  task automatic loc(input logic wr, input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_in);
    loc_req_in = {1'b1, wr, a, d};
    @(negedge clk_in);
    loc_req_in = '0;
  endtask
  // Local read, result noted first
  task automatic lr(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back({6'h00, e});
    loc(1'b0, a, 16'h0000);
  endtask
  // Host write and host read of a mailbox word
  task automatic hw(input logic [3:0] i, input logic [15:0] d, output logic ok);
    logic [21:0] r;
    u_hbm_host_model.cycle(3'b001, {HBASE, i, 1'b0}, d, r, ok);
  endtask
  task automatic hr(input logic [3:0] i, input logic [15:0] e);
    logic [21:0] r;
    logic        ok;
    exp_q.push_back({6'h00, e});
    u_hbm_host_model.cycle(3'b010, {HBASE, i, 1'b0}, 16'h0000, r, ok);
  endtask
  // Grant then finish one transfer
  task automatic dma_run();
    dma_gnt_in = 1'b1;
    repeat (3) @(negedge clk_in);
    chk("master", 22'h1, 22'(dma_master_out));
    chk("req", 22'h0, 22'(dma_req_out));
    dma_gnt_in = 1'b0;
    dma_done_in = 1'b1;
    @(negedge clk_in);
    dma_done_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk("master", 22'h0, 22'(dma_master_out));
  endtask
  // Verdict
  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Result watcher: oldest note against each result seen
  always @(posedge clk_in) begin
    if (rd_pend || (host_reply_out && !reply_d && host_dal_oe_out)) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("wrong value result expected none seen %h", host_dal_out);
      end else begin
        chk("result", exp_q.pop_front(), rd_pend ? {6'h00, loc_rdata_out} : host_dal_out);
      end
    end
    n_nmi += int'(loc_nmi_out === 1'b1);
    n_lvl5 += int'(loc_lvl5_irq_out === 1'b1);
    rd_pend = loc_req_in.sel && !loc_req_in.wr;
    reply_d = host_reply_out;
  end

  // Watchdog
  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end

  // Main sequence
  initial begin
    logic [21:0] rd;
    logic        ok;
    logic [15:0] v;
    logic [4:0]  i;
    int          k;
    rst_n_in = 1'b0;
    dma_gnt_in = 1'b0;
    dma_done_in = 1'b0;
    loc_req_in = '0;
    rd_pend = 1'b0;
    reply_d = 1'b0;
    v = 16'($urandom(21554));
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    rst_n_in = 1'b1;
    // Before init only word zero answers the host
    lr(hbm_pkg::LOC_CTRL_IDX, 16'h0000);
    hw(4'h5, v, ok);
    chk("accept", 22'h0, 22'(ok));
    hw(4'h0, v, ok);
    hr(4'h0, v);
    lr(5'h00, v);
    chk("nmi", 22'h1, 22'(n_nmi));
    chk("lvl5", 22'h0, 22'(n_lvl5));
    // After init every word is shared both ways
    loc(1'b1, hbm_pkg::LOC_CTRL_IDX, 16'h0001);
    hr(4'h5, 16'h0000);
    for (i = 0; i < 16; i++) begin
      v = 16'($urandom);
      hw(i[3:0], v, ok);
      hr(i[3:0], v);
      v = ~v;
      loc(1'b1, i, v);
      lr(i, v);
      hr(i[3:0], v);
    end
    chk("nmi", 22'h2, 22'(n_nmi));
    chk("lvl5", 22'h2, 22'(n_lvl5));
    fork
      lr(5'h0F, v);
      begin
        @(negedge clk_in);
        hr(4'hF, v);
      end
    join
    // Vector delivery on acknowledge
    for (k = 0; k < 3; k++) begin
      v = (k == 0) ? 16'h0000 : (k == 1) ? 16'h03FC : {6'h00, 8'($urandom), 2'b00};
      loc(1'b1, hbm_pkg::LOC_VEC_IDX, v);
      repeat (2) @(negedge clk_in);
      chk("irq", 22'h1, 22'(host_irq4_out));
      exp_q.push_back({6'h00, v});
      u_hbm_host_model.cycle(3'b100, 22'h0, 16'h0000, rd, ok);
      chk("irq", 22'h0, 22'(host_irq4_out));
    end
    loc(1'b1, hbm_pkg::LOC_VEC_IDX, 16'h0400);
    repeat (3) @(negedge clk_in);
    chk("irq", 22'h0, 22'(host_irq4_out));
    u_hbm_host_model.cycle(3'b100, 22'h0, 16'h0000, rd, ok);
    chk("accept", 22'h0, 22'(ok));
    lr(hbm_pkg::LOC_VEC_IDX, 16'h0000);
    // Every transfer direction
    for (k = 0; k < 4; k++) begin
      loc(1'b1, hbm_pkg::LOC_CTRL_IDX, {10'h000, 2'(k), 4'h9});
      @(negedge clk_in);
      chk("req", 22'h1, 22'(dma_req_out));
      chk("dir", 22'(k), 22'(dma_dir_out));
      chk("master", 22'h0, 22'(dma_master_out));
      dma_run();
    end
    // Host boot after a fresh reset
    rst_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rst_n_in = 1'b1;
    loc(1'b1, hbm_pkg::LOC_CTRL_IDX, 16'h0006);
    @(negedge clk_in);
    chk("hold", 22'h1, 22'(boot_hold_out));
    hw(4'h0, 16'($urandom), ok);
    chk("load", 22'h1, 22'(boot_load_out));
    chk("dir", 22'h1, 22'(dma_dir_out));
    dma_run();
    chk("load", 22'h0, 22'(boot_load_out | boot_hold_out));
    chk("left", 22'h0, 22'(exp_q.size()));
    complete_run();
  end
endmodule // hbm_mailbox_top_test
